// [logic/lsc_pkg.sv]
// Package of constants and types for the load/store and coprocessor access block.
package lsc_pkg;
  localparam int          LSC_ELEM_BYTES    = 8;
  localparam int          LSC_ADDR_W        = 64;
  localparam int          LSC_LANE_BITS_32  = 2;
  localparam int          LSC_LANE_BITS_64  = 3;
  localparam logic [2:0]  LSC_LEN_BYTE      = 3'h0;
  localparam logic [2:0]  LSC_LEN_HALF      = 3'h1;
  localparam logic [2:0]  LSC_LEN_WORD      = 3'h3;
  localparam logic [2:0]  LSC_LEN_DOUBLE    = 3'h7;
  localparam logic [2:0]  LSC_AR_MISALIGN   = 3'h2;
  localparam logic [1:0]  LSC_CP_SYSCTL     = 2'h0;
  localparam logic [2:0]  LSC_ATTR_UNCACHED = 3'h2;
  localparam logic [2:0]  LSC_ATTR_CACHED   = 3'h3;
  localparam logic [63:0] LSC_SEG_MASK      = 64'hFFFF_FFFF_E000_0000;
  localparam logic [63:0] LSC_SEG_KSEG0     = 64'hFFFF_FFFF_8000_0000;
  localparam logic [63:0] LSC_SEG_KSEG1     = 64'hFFFF_FFFF_A000_0000;
  localparam logic [63:0] LSC_PHYS_MASK     = 64'h0000_0000_1FFF_FFFF;

  typedef enum logic [2:0] {
    LSC_OP_LOAD,
    LSC_OP_STORE,
    LSC_OP_CWLOAD,
    LSC_OP_CDLOAD,
    LSC_OP_CWSTORE,
    LSC_OP_CDSTORE,
    LSC_OP_CFUNC,
    LSC_OP_NONE
  } lsc_op_t;
endpackage

// [logic/lsc_lane_gen.sv]
// Byte lane and data positioning within one memory element.
`timescale 1ns/1ps
module lsc_lane_gen
  import lsc_pkg::*;
#(
  parameter int ELEM_BYTES = LSC_ELEM_BYTES
) (
  // Access description.
  input  wire logic [2:0]              accessByteCount,
  input  wire logic [2:0]              lowAddr,
  input  wire logic                    bigEndian,
  input  wire logic [63:0]             storeValue,
  // Lanes and positioned data.
  output logic      [ELEM_BYTES-1:0]   laneMask,
  output logic      [63:0]             laneData
);
  if (ELEM_BYTES != 4 && ELEM_BYTES != 8) begin : g_bad_elem
    $error("ELEM_BYTES must be 4 or 8");
  end

  localparam int LB = (ELEM_BYTES == 8) ? LSC_LANE_BITS_64 : LSC_LANE_BITS_32;

  // Lowest lane used; the address names the lowest lane when little-endian and the highest lane when big-endian.
  logic [2:0] baseLane;
  logic [3:0] nBytes;
  logic [6:0] shiftBits;

  always_comb begin
    nBytes = {1'b0, accessByteCount} + 4'h1;
    if (bigEndian)
      baseLane = 3'(ELEM_BYTES) - 3'(lowAddr[LB-1:0]) - nBytes[2:0];
    else
      baseLane = 3'(lowAddr[LB-1:0]);
    laneMask = ELEM_BYTES'(((16'h1 << nBytes) - 16'h1) << baseLane);
    shiftBits = {baseLane, 3'h0};
    laneData = storeValue << shiftBits;
  end
endmodule

// [logic/lsc_access_unit.sv]
// Load/store address, translation, lane and coprocessor transfer unit.
`timescale 1ns/1ps
module lsc_access_unit
  import lsc_pkg::*;
#(
  parameter int ELEM_BYTES = LSC_ELEM_BYTES
) (
  // Clock and reset.
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Request from the pipeline.
  input  wire logic                  reqValid,
  input  wire lsc_op_t               reqOp,
  input  wire logic [63:0]           virtualAddr,
  input  wire logic [2:0]            accessByteCount,
  input  wire logic                  instrOrDataSel,
  input  wire logic                  vectorAccess,
  input  wire logic                  bigEndian,
  input  wire logic [63:0]           storeData,
  input  wire logic [1:0]            coprocUnit,
  input  wire logic [4:0]            coprocRegSpecifier,
  input  wire logic [24:0]           coprocFunction,
  input  wire logic [2:0]            archRevisionField,
  // Translation lookup.
  output logic                       lookupValid,
  output logic [63:0]                lookupVirtualAddr,
  output logic                       lookupInstrOrData,
  input  wire logic                  lookupDone,
  input  wire logic                  lookupHit,
  input  wire logic                  lookupPermitted,
  input  wire logic [63:0]           lookupPhysAddr,
  input  wire logic [2:0]            lookupCacheAttr,
  // Memory hierarchy.
  output logic                       memValid,
  output logic                       memWrite,
  output logic [63:0]                memPhysAddr,
  output logic [2:0]                 memCacheAttr,
  output logic [2:0]                 memByteCount,
  output logic [ELEM_BYTES-1:0]      memByteEnable,
  output logic                       memFillElement,
  output logic                       memInstrOrData,
  output logic [63:0]                memWriteData,
  input  wire logic                  memDone,
  input  wire logic [63:0]           memReadData,
  // Coprocessor ports.
  output logic                       cpValid,
  output logic [1:0]                 cpUnit,
  output logic [4:0]                 cpRegSpecifier,
  output logic                       cpWordLoad,
  output logic                       cpDoubleLoad,
  output logic                       cpWordStore,
  output logic                       cpDoubleStore,
  output logic                       cpFunctionIssue,
  output logic [24:0]                cpFunction,
  output logic [63:0]                cpLoadData,
  input  wire logic                  cpStoreValid,
  input  wire logic [63:0]           cpStoreData,
  // Completion to the pipeline.
  output logic                       respValid,
  output logic [63:0]                respElement,
  output logic [ELEM_BYTES-1:0]      respByteValid,
  output logic                       respFault,
  output logic                       respMisalignTrap,
  output logic                       misalignSupported,
  output logic                       busy
);
  if (ELEM_BYTES != 4 && ELEM_BYTES != 8) begin : g_bad_elem
    $error("ELEM_BYTES must be 4 or 8");
  end

  localparam int LB = (ELEM_BYTES == 8) ? LSC_LANE_BITS_64 : LSC_LANE_BITS_32;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_XLATE,
    ST_CPGET,
    ST_MEM,
    ST_CPPUT,
    ST_DONE
  } lsc_state_t;

  typedef struct packed {
    lsc_state_t            state;
    lsc_op_t               op;
    logic [63:0]           virtual_addr;
    logic [2:0]            cnt;
    logic                  instr_or_data_sel;
    logic                  big;
    logic [63:0]           data;
    logic [1:0]            unit;
    logic [4:0]            spec;
    logic [24:0]           func;
    logic                  lookupValid;
    logic                  memValid;
    logic                  memWrite;
    logic [63:0]           memPhysAddr;
    logic [2:0]            memCacheAttr;
    logic [ELEM_BYTES-1:0] memByteEnable;
    logic                  memFill;
    logic [63:0]           memWriteData;
    logic                  cpValid;
    logic [5:0]            cpKind;
    logic [63:0]           cpLoadData;
    logic                  respValid;
    logic [63:0]           respElement;
    logic [ELEM_BYTES-1:0] respByteValid;
    logic                  respFault;
    logic                  respMisalign;
    logic                  misalignOk;
    logic                  busy;
  } lsc_regs_t;

  lsc_regs_t r_reg;
  lsc_regs_t r_next;

  // Lanes are computed from the captured request.
  logic [ELEM_BYTES-1:0] laneMask;
  logic [63:0]           laneData;

  lsc_lane_gen #(
    .ELEM_BYTES      (ELEM_BYTES)
  ) u_lanes (
    .accessByteCount (r_reg.cnt),
    .lowAddr         (r_reg.virtual_addr[2:0]),
    .bigEndian       (r_reg.big),
    .storeValue      (r_reg.data),
    .laneMask        (laneMask),
    .laneData        (laneData)
  );

  // True when the access runs past the end of its memory element, or is a half, word or double access not aligned to its size.
  function automatic logic misaligned(input logic [63:0] va,
                                      input logic [2:0] cnt);
    logic [3:0] endByte;
    endByte = {1'b0, 3'(va[LB-1:0])} + {1'b0, cnt};
    return (endByte >= 4'(ELEM_BYTES)) || ((va[2:0] & cnt) != 3'h0 &&
           (cnt == LSC_LEN_HALF || cnt == LSC_LEN_WORD ||
            cnt == LSC_LEN_DOUBLE));
  endfunction

  function automatic logic is_load(input lsc_op_t op);
    return op == LSC_OP_LOAD || op == LSC_OP_CWLOAD || op == LSC_OP_CDLOAD;
  endfunction

  // Index of the lowest enabled lane.
  function automatic logic [2:0] laneBase(input logic [ELEM_BYTES-1:0] m);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = ELEM_BYTES - 1; i >= 0; i--) begin
      if (m[i])
        idx = 3'(i);
    end
    return idx;
  endfunction

  logic [63:0] segBase;

  always_comb begin
    r_next = r_reg;
    r_next.respValid = 1'b0;
    r_next.misalignOk = (archRevisionField >= LSC_AR_MISALIGN);
    segBase = r_reg.virtual_addr & LSC_SEG_MASK;
    unique case (r_reg.state)
      ST_IDLE: begin
        if (reqValid && reqOp != LSC_OP_NONE) begin
          r_next.op   = reqOp;
          r_next.virtual_addr = virtualAddr;
          r_next.instr_or_data_sel = instrOrDataSel;
          r_next.big  = bigEndian;
          r_next.unit = coprocUnit;
          r_next.spec = coprocRegSpecifier;
          r_next.func = coprocFunction;
          r_next.data = storeData;
          r_next.respFault = 1'b0;
          r_next.respMisalign = 1'b0;
          unique case (reqOp)
            LSC_OP_CWLOAD, LSC_OP_CWSTORE: r_next.cnt = LSC_LEN_WORD;
            LSC_OP_CDLOAD, LSC_OP_CDSTORE: r_next.cnt = LSC_LEN_DOUBLE;
            default: r_next.cnt = accessByteCount;
          endcase
          if (reqOp == LSC_OP_CFUNC) begin
            r_next.cpValid = 1'b1;
            r_next.cpKind = 6'h20;
            r_next.state = ST_DONE;
          end else if (reqOp != LSC_OP_LOAD && reqOp != LSC_OP_STORE &&
                       coprocUnit == LSC_CP_SYSCTL) begin
            r_next.respFault = 1'b1;
            r_next.state = ST_DONE;
          end else if (misaligned(virtualAddr, r_next.cnt) && !vectorAccess
                       && archRevisionField < LSC_AR_MISALIGN) begin
            r_next.respMisalign = 1'b1;
            r_next.state = ST_DONE;
          end else begin
            // Vector accesses pass even when misaligned.
            r_next.state = ST_XLATE;
          end
        end
      end
      ST_XLATE: begin
        if (segBase == LSC_SEG_KSEG0 || segBase == LSC_SEG_KSEG1) begin
          r_next.memPhysAddr = r_reg.virtual_addr & LSC_PHYS_MASK;
          r_next.memCacheAttr = (segBase == LSC_SEG_KSEG1) ?
                                LSC_ATTR_UNCACHED : LSC_ATTR_CACHED;
          r_next.state = ST_CPGET;
        end else if (!r_reg.lookupValid) begin
          r_next.lookupValid = 1'b1;
        end else if (lookupDone) begin
          r_next.lookupValid = 1'b0;
          if (!lookupHit || !lookupPermitted) begin
            r_next.respFault = 1'b1;
            r_next.state = ST_DONE;
          end else begin
            r_next.memPhysAddr = lookupPhysAddr;
            r_next.memCacheAttr = lookupCacheAttr;
            r_next.state = ST_CPGET;
          end
        end
      end
      ST_CPGET: begin
        if (r_reg.op == LSC_OP_CWSTORE || r_reg.op == LSC_OP_CDSTORE) begin
          if (!r_reg.cpValid) begin
            r_next.cpValid = 1'b1;
            r_next.cpKind = (r_reg.op == LSC_OP_CWSTORE) ? 6'h04 : 6'h08;
          end else if (cpStoreValid) begin
            r_next.cpValid = 1'b0;
            r_next.cpKind = 6'h00;
            r_next.data = (r_reg.op == LSC_OP_CWSTORE) ?
                          {32'h0, cpStoreData[31:0]} : cpStoreData;
            r_next.state = ST_MEM;
          end
        end else begin
          r_next.state = ST_MEM;
        end
      end
      ST_MEM: begin
        if (!r_reg.memValid) begin
          r_next.memValid = 1'b1;
          r_next.memWrite = !is_load(r_reg.op);
          r_next.memByteEnable = laneMask;
          r_next.memWriteData = laneData;
          r_next.memFill = is_load(r_reg.op) &&
                           r_reg.memCacheAttr != LSC_ATTR_UNCACHED;
          r_next.memPhysAddr = r_reg.memPhysAddr;
        end else if (memDone) begin
          r_next.memValid = 1'b0;
          r_next.memWrite = 1'b0;
          r_next.respElement = memReadData;
          r_next.respByteValid = (r_reg.memFill) ?
                                 '1 : r_reg.memByteEnable;
          if (r_reg.op == LSC_OP_CWLOAD || r_reg.op == LSC_OP_CDLOAD) begin
            r_next.cpValid = 1'b1;
            r_next.cpKind = (r_reg.op == LSC_OP_CWLOAD) ? 6'h01 : 6'h02;
            r_next.cpLoadData = (r_reg.op == LSC_OP_CWLOAD) ?
              {32'h0, 32'(memReadData >> {laneBase(r_reg.memByteEnable),
               3'h0})} : memReadData;
            r_next.state = ST_CPPUT;
          end else begin
            r_next.state = ST_DONE;
          end
        end
      end
      ST_CPPUT: begin
        r_next.cpValid = 1'b0;
        r_next.cpKind = 6'h00;
        r_next.state = ST_DONE;
      end
      ST_DONE: begin
        r_next.cpValid = 1'b0;
        r_next.cpKind = 6'h00;
        r_next.respValid = 1'b1;
        r_next.state = ST_IDLE;
      end
    endcase
    r_next.busy = (r_next.state != ST_IDLE);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.state <= ST_IDLE;
      r_reg.op <= LSC_OP_NONE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign lookupValid       = r_reg.lookupValid;
  assign lookupVirtualAddr = r_reg.virtual_addr;
  assign lookupInstrOrData = r_reg.instr_or_data_sel;
  assign memValid          = r_reg.memValid;
  assign memWrite          = r_reg.memWrite;
  assign memPhysAddr       = r_reg.memPhysAddr;
  assign memCacheAttr      = r_reg.memCacheAttr;
  assign memByteCount      = r_reg.cnt;
  assign memByteEnable     = r_reg.memByteEnable;
  assign memFillElement    = r_reg.memFill;
  assign memInstrOrData    = r_reg.instr_or_data_sel;
  assign memWriteData      = r_reg.memWriteData;
  assign cpValid           = r_reg.cpValid;
  assign cpUnit            = r_reg.unit;
  assign cpRegSpecifier    = r_reg.spec;
  assign cpWordLoad        = r_reg.cpKind[0];
  assign cpDoubleLoad      = r_reg.cpKind[1];
  assign cpWordStore       = r_reg.cpKind[2];
  assign cpDoubleStore     = r_reg.cpKind[3];
  assign cpFunctionIssue   = r_reg.cpKind[5];
  assign cpFunction        = r_reg.func;
  assign cpLoadData        = r_reg.cpLoadData;
  assign respValid         = r_reg.respValid;
  assign respElement       = r_reg.respElement;
  assign respByteValid     = r_reg.respByteValid;
  assign respFault         = r_reg.respFault;
  assign respMisalignTrap  = r_reg.respMisalign;
  assign misalignSupported = r_reg.misalignOk;
  assign busy              = r_reg.busy;
endmodule

// [verif/lsc_access_unit_assertions.sv]
// Concurrent checks on the ports of the access unit.
`timescale 1ns/1ps
module lsc_access_unit_checker
  import lsc_pkg::*;
#(
  parameter int ELEM_BYTES = LSC_ELEM_BYTES
) (
  // Clock, reset and request.
  input wire logic core_clk, rst, reqValid, instrOrDataSel, vectorAccess,
  input wire lsc_op_t reqOp,
  input wire logic [63:0] virtualAddr, lookupVirtualAddr, memPhysAddr,
  input wire logic [2:0] accessByteCount, archRevisionField,
  input wire logic [1:0] coprocUnit, cpUnit,
  input wire logic [24:0] coprocFunction, cpFunction,
  // Far side and completion.
  input wire logic lookupValid, lookupInstrOrData, lookupDone, lookupHit,
  input wire logic memValid, memWrite, memInstrOrData, memDone, busy,
  input wire logic [2:0] memCacheAttr, memByteCount,
  input wire logic [ELEM_BYTES-1:0] memByteEnable,
  input wire logic cpValid, cpFunctionIssue, cpWordStore, cpStoreValid,
  input wire logic respValid, respFault, respMisalignTrap, misalignSupported
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic [63:0] addrQ_reg;
  logic        iodQ_reg;
  wire taken = reqValid && !busy && reqOp != LSC_OP_NONE;
  wire cpXfer = reqOp inside {LSC_OP_CWLOAD, LSC_OP_CDLOAD,
                              LSC_OP_CWSTORE, LSC_OP_CDSTORE};
  wire k1Load = taken && reqOp == LSC_OP_LOAD &&
                (virtualAddr[2:0] & accessByteCount) == 3'h0 &&
                (virtualAddr & LSC_SEG_MASK) == LSC_SEG_KSEG1;
  wire misTrap = taken && reqOp inside {LSC_OP_LOAD, LSC_OP_STORE} &&
                 !vectorAccess && archRevisionField < LSC_AR_MISALIGN &&
                 accessByteCount == LSC_LEN_WORD && virtualAddr[1:0] != 2'h0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addrQ_reg <= '0;
      iodQ_reg  <= 1'b0;
    end else if (taken) begin
      addrQ_reg <= virtualAddr;
      iodQ_reg  <= instrOrDataSel;
    end
  end

  AST_REV_FLAG: assert property (!$past(rst) |-> misalignSupported ==
    ($past(archRevisionField) >= LSC_AR_MISALIGN)) else $error("rev flag");
  AST_LANE_COUNT: assert property (memValid && memWrite |->
    $countones(memByteEnable) == memByteCount + 1) else $error("lanes");
  AST_UNMAPPED: assert property (k1Load |-> !lookupValid [*3] ##[0:2]
    (memValid && memPhysAddr == (addrQ_reg & LSC_PHYS_MASK) &&
     memCacheAttr == LSC_ATTR_UNCACHED)) else $error("unmapped access");
  AST_MEM_HOLD: assert property (memValid && !memDone |=> memValid &&
    $stable(memPhysAddr) && $stable(memByteEnable)) else $error("mem hold");
  AST_IOD_MEM: assert property (memValid |-> memInstrOrData == iodQ_reg)
    else $error("mem instr flag");
  AST_LOOKUP_REQ: assert property (lookupValid |->
    lookupVirtualAddr == addrQ_reg && lookupInstrOrData == iodQ_reg)
    else $error("lookup request");
  AST_LOOKUP_FAULT: assert property (lookupValid && lookupDone && !lookupHit
    |=> !memValid throughout (##[0:3] (respValid && respFault)))
    else $error("lookup fault");
  AST_SYSCTL: assert property (taken && cpXfer && coprocUnit == LSC_CP_SYSCTL
    |=> !cpValid throughout (##[0:2] (respValid && respFault)))
    else $error("system unit transfer");
  AST_FUNC: assert property (taken && reqOp == LSC_OP_CFUNC && coprocUnit !=
    LSC_CP_SYSCTL |=> cpValid && cpFunctionIssue && cpUnit == $past(coprocUnit)
    && cpFunction == $past(coprocFunction) ##1 respValid) else $error("func");
  AST_TRAP: assert property (misTrap |=> !memValid throughout
    (##[0:2] (respValid && respMisalignTrap))) else $error("misalign trap");
  AST_RESP_PULSE: assert property (respValid |=> !respValid)
    else $error("resp pulse");

  COV_UNMAPPED: cover property (k1Load);
  COV_TRAP: cover property (misTrap);
  COV_CPSTORE: cover property (cpValid && cpWordStore && cpStoreValid);
endmodule

bind lsc_access_unit lsc_access_unit_checker #(.ELEM_BYTES(ELEM_BYTES)) u_chk (.*);

// [verif/lsc_far_model.sv]
// Translation, memory and coprocessor responder on the far side.
`timescale 1ns/1ps
module lsc_far_model (
  // Requests from the unit.
  input wire logic core_clk, rst, lookupValid, memValid, memWrite, cpValid,
  input wire logic cpWordStore, cpDoubleStore, lookupDeny,
  input wire logic [3:0] farDelay,
  input wire logic [63:0] lookupVirtualAddr, memPhysAddr, memWriteData,
  input wire logic [7:0] memByteEnable,
  // Answers.
  output logic lookupDone, lookupHit, lookupPermitted, memDone, cpStoreValid,
  output logic [63:0] lookupPhysAddr, memReadData, cpStoreData,
  output logic [2:0] lookupCacheAttr
);
  logic [63:0] mem [16];
  logic [63:0] lastRd;
  logic [3:0]  waitCnt;
  wire ask = (lookupValid & ~lookupDone) | (memValid & ~memDone) |
             (cpValid & (cpWordStore | cpDoubleStore) & ~cpStoreValid);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {lookupDone, memDone, cpStoreValid} <= '0;
      waitCnt <= '0;
      lastRd <= '0;
      for (int i = 0; i < 16; i++) mem[i] <= '0;
    end else begin
      {lookupDone, memDone, cpStoreValid} <= '0;
      if (ask && waitCnt < farDelay) waitCnt <= waitCnt + 4'h1;
      else if (ask) begin
        waitCnt <= '0;
        lookupDone <= lookupValid;
        memDone <= memValid;
        cpStoreValid <= cpValid;
        lastRd <= mem[memPhysAddr[6:3]];
        for (int i = 0; i < 8; i++)
          if (memValid && memWrite && memByteEnable[i])
            mem[memPhysAddr[6:3]][i*8 +: 8] <= memWriteData[i*8 +: 8];
      end
    end
  end

  // Read data, lookup address and store data read as garbage outside their strobe so stale values are not used.
  assign memReadData = memDone ? lastRd : ~lastRd;
  assign lookupHit = ~lookupDeny;
  assign lookupPermitted = 1'b1;
  assign lookupCacheAttr = 3'h3;
  assign lookupPhysAddr = lookupDone ? lookupVirtualAddr + 64'h40 : '1;
  assign cpStoreData = {64{~cpStoreValid}} ^ 64'hC0DE_0000_5A5A_A5A5;
endmodule

// [verif/tb.sv]
// Self-checking bench for the access unit.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb;
  import lsc_pkg::*;
  logic core_clk, rst, reqValid, instrOrDataSel, vectorAccess, bigEndian;
  lsc_op_t reqOp;
  logic [63:0] virtualAddr, storeData, lookupVirtualAddr, lookupPhysAddr;
  logic [63:0] memPhysAddr, memWriteData, memReadData, cpLoadData;
  logic [63:0] cpStoreData, respElement, mAddr, cLd;
  logic [2:0] accessByteCount, archRevisionField, lookupCacheAttr, mAttr;
  logic [2:0] memCacheAttr, memByteCount;
  logic [1:0] coprocUnit, cpUnit, cU;
  logic [4:0] coprocRegSpecifier, cpRegSpecifier, cR, cFl;
  logic [24:0] coprocFunction, cpFunction, cFn;
  logic [7:0] memByteEnable, respByteValid, mBe;
  logic [3:0] farDelay;
  logic lookupValid, lookupInstrOrData, lookupDone, lookupHit, lookupDeny;
  logic lookupPermitted, memValid, memWrite, memFillElement, memInstrOrData;
  logic memDone, cpValid, cpWordLoad, cpDoubleLoad, cpWordStore;
  logic cpDoubleStore, cpFunctionIssue, cpStoreValid, respValid, respFault;
  logic respMisalignTrap, misalignSupported, busy, lkSeen, cpSeen, mFill, mIod;
  int error_cnt, total_checks, cyc;
  localparam logic [63:0] K0 = LSC_SEG_KSEG0;
  localparam logic [63:0] K1 = LSC_SEG_KSEG1;

  lsc_access_unit DUT (.*);
  lsc_far_model u_far (.*);

  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (lookupValid) lkSeen <= 1'b1;
    if (memValid) begin
      {mBe, mAddr, mAttr, mFill, mIod} <= {memByteEnable, memPhysAddr,
        memCacheAttr, memFillElement, memInstrOrData};
    end
    if (cpValid) begin
      {cU, cR, cFn, cLd, cpSeen} <= {cpUnit, cpRegSpecifier, cpFunction,
        cpLoadData, 1'b1};
      cFl <= {cpWordLoad, cpDoubleLoad, cpWordStore, cpDoubleStore,
        cpFunctionIssue};
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic doReq(input lsc_op_t op, input logic [63:0] va,
                       input logic [2:0] len, input logic [63:0] sd,
                       input logic [1:0] unit);
    int n;
    n = 0;
    {lkSeen, cpSeen} = 2'b00;
    reqOp = op;
    {virtualAddr, accessByteCount, storeData} = {va, len, sd};
    coprocUnit = unit;
    reqValid = 1'b1;
    @(posedge core_clk);
    #1 reqValid = 1'b0;
    while (respValid !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1 n++;
    end
    `CHK("respValid", 1'b1, respValid)
    @(posedge core_clk);
    #1;
  endtask

  task automatic t_lanes;
    doReq(LSC_OP_STORE, K1 + 8, 7, 64'h1122_3344_5566_7788, 1);
    doReq(LSC_OP_STORE, K1 + 11, 0, 64'hAB, 1);
    `CHK("mBe", 8'h08, mBe)
    doReq(LSC_OP_LOAD, K1 + 8, 7, 0, 1);
    `CHK("elem", 64'h1122_3344_AB66_7788, respElement)
    doReq(LSC_OP_LOAD, K1 + 10, 1, 0, 1);
    `CHK("byteValid", 8'h0C, respByteValid)
    `CHK("pAddr", 64'hA, mAddr)
    `CHK("noFill", 1'b0, mFill)
    bigEndian = 1'b1;
    doReq(LSC_OP_STORE, K1 + 18, 1, 64'h1234, 1);
    `CHK("beLanes", 8'h30, mBe)
    doReq(LSC_OP_LOAD, K1 + 16, 7, 0, 1);
    `CHK("beHalf", 16'h1234, respElement[47:32])
    bigEndian = 1'b0;
    $display("lanes test done");
  endtask

  task automatic t_misalign;
    for (int r = 1; r < 3; r++) begin
      archRevisionField = 3'(r);
      @(posedge core_clk);
      #1 `CHK("support", r >= 2, misalignSupported)
      doReq(LSC_OP_LOAD, K1 + 2, 3, 0, 1);
      `CHK("trap", r < 2, respMisalignTrap)
    end
    archRevisionField = 3'h1;
    vectorAccess = 1'b1;
    doReq(LSC_OP_LOAD, K1 + 2, 3, 0, 1);
    `CHK("vecTrap", 1'b0, respMisalignTrap)
    {vectorAccess, archRevisionField} = {1'b0, 3'h2};
    $display("misalign test done");
  endtask

  task automatic t_translate;
    doReq(LSC_OP_LOAD, K0 + 24, 7, 0, 1);
    `CHK("k0Lookup", 1'b0, lkSeen)
    `CHK("k0Attr", LSC_ATTR_CACHED, mAttr)
    `CHK("fill", 1'b1, mFill)
    {instrOrDataSel, farDelay} = {1'b1, 4'h3};
    doReq(LSC_OP_LOAD, 64'h1000, 3, 0, 1);
    `CHK("lookup", 1'b1, lkSeen)
    `CHK("mapAddr", 64'h1040, mAddr)
    `CHK("iod", 1'b1, mIod)
    {instrOrDataSel, lookupDeny} = 2'b01;
    doReq(LSC_OP_LOAD, 64'h2000, 3, 0, 1);
    `CHK("fault", 1'b1, respFault)
    lookupDeny = 1'b0;
    $display("translate test done");
  endtask

  task automatic t_coproc;
    farDelay = 4'h2;
    coprocRegSpecifier = 5'h1D;
    doReq(LSC_OP_STORE, K1 + 32, 7, 64'hFEDC_BA98_7654_3210, 1);
    doReq(LSC_OP_CWLOAD, K1 + 32, 3, 0, 1);
    `CHK("wlFlags", 5'h10, cFl)
    `CHK("wlData", 32'h7654_3210, cLd[31:0])
    `CHK("wlReg", 5'h1D, cR)
    doReq(LSC_OP_CDLOAD, K1 + 32, 7, 0, 2);
    `CHK("dlData", 64'hFEDC_BA98_7654_3210, cLd)
    `CHK("dlUnit", 2'h2, cU)
    `CHK("dlFlags", 5'h08, cFl)
    doReq(LSC_OP_CWSTORE, K1 + 40, 3, 0, 3);
    doReq(LSC_OP_LOAD, K1 + 40, 3, 0, 1);
    `CHK("wsData", 32'h5A5A_A5A5, respElement[31:0])
    doReq(LSC_OP_CDSTORE, K1 + 48, 7, 0, 1);
    doReq(LSC_OP_LOAD, K1 + 48, 7, 0, 1);
    `CHK("dsData", 64'hC0DE_0000_5A5A_A5A5, respElement)
    for (int k = 2; k < 6; k++) begin
      doReq(lsc_op_t'(k), K1 + 32, (k % 2) ? 3'h7 : 3'h3, 0, 0);
      `CHK("sysFault", 1'b1, respFault)
      `CHK("sysCp", 1'b0, cpSeen)
    end
    coprocFunction = 25'h1AB_CDEF;
    doReq(LSC_OP_CFUNC, 0, 0, 0, 3);
    `CHK("fnFlags", 5'h01, cFl)
    `CHK("fnVal", 25'h1AB_CDEF, cFn)
    `CHK("fnUnit", 2'h3, cU)
    $display("coproc test done");
  endtask

  initial begin
    {rst, reqValid, instrOrDataSel, vectorAccess, bigEndian} = 5'b10000;
    reqOp = LSC_OP_NONE;
    {virtualAddr, storeData, accessByteCount} = '0;
    {coprocUnit, coprocRegSpecifier, coprocFunction} = '0;
    {archRevisionField, farDelay, lookupDeny} = {3'h2, 4'h0, 1'b0};
    {error_cnt, total_checks} = '0;
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    t_lanes();
    t_misalign();
    t_translate();
    t_coproc();
    end_sim();
  end

  initial begin
    cyc = 0;
    forever begin
      @(posedge core_clk);
      cyc++;
      if (cyc > 20000) begin
        error_cnt++;
        end_sim();
      end
    end
  end
endmodule
